// ### shared/acs_pkg.sv
// constants for the conversion start and host port block
// assumes one 10 MHz conversion clock for all logic
package acs_pkg;
  localparam int unsigned ACS_WORD_W = 16;
  localparam int unsigned ACS_PAIRS = 3;
  localparam int unsigned ACS_CTRL_W = 32;
  localparam logic [31:0] ACS_CTRL_RESET = 32'h000003FF;
  localparam int unsigned ACS_SEQ_BIT = 23;
  localparam int unsigned ACS_CLK_NS = 100;
  localparam int unsigned ACS_CONV_NS = 1400;
  localparam int unsigned ACS_CONV_CYC = (ACS_CONV_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
  localparam int unsigned ACS_CNT_W = 5;
  localparam int unsigned ACS_BITS_W = 5;
  localparam logic [1:0] ACS_IDX_A = 2'h0;
  localparam logic [1:0] ACS_IDX_B = 2'h1;
  localparam logic [1:0] ACS_IDX_C = 2'h2;
  typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_DONE} acs_state_e;
endpackage : acs_pkg

// ### logic/acs_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes asynchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module acs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : acs_sync
`default_nettype wire

// ### logic/acs_pair.sv
// one channel pair conversion sequencer
// assumes start already synchronised; one cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module acs_pair (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_hold_level,
  input wire logic i_check_hold,
  output logic o_busy,
  output logic o_done,
  output logic o_power_down
);
  logic [acs_pkg::ACS_CNT_W-1:0] cnt;
  // conversion timer, aborted by reset
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      cnt <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        cnt <= acs_pkg::ACS_CNT_W'(acs_pkg::ACS_CONV_CYC - 1);
      end else if (o_busy) begin
        if (cnt == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
  // start low mid conversion, with i_check_hold set, puts the pair in partial power-down
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_power_down <= 1'b0;
    end else if (i_start) begin
      o_power_down <= 1'b0;
    end else if (o_busy && i_check_hold && !i_hold_level) begin
      o_power_down <= 1'b1;
    end
  end
endmodule : acs_pair
`default_nettype wire

// ### logic/acs_core.sv
// conversion start control, busy/interrupt and host port of a six channel converter
// assumes host pins asynchronous; results arrive on i_result_* from the analog core
//
// Implementation choices: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acs_core (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_config_source_select,
  input wire logic i_interface_select,
  input wire logic i_busy_as_int,
  input wire logic i_start_pair_a,
  input wire logic i_start_pair_b,
  input wire logic i_start_pair_c,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_frame_sync_n,
  input wire logic i_sclk,
  input wire logic i_sel_a,
  input wire logic [15:0] i_db,
  input wire logic i_ctrl_we,
  input wire logic [31:0] i_ctrl_wdata,
  input wire logic [15:0] i_result_a,
  input wire logic [15:0] i_result_b,
  input wire logic [15:0] i_result_c,
  output logic [15:0] o_db,
  output logic [15:0] o_db_oe,
  output logic o_serial_out_a,
  output logic o_serial_out_a_oe,
  output logic o_busy_int,
  output logic [2:0] o_power_down,
  output logic [31:0] o_control_word
);
  logic [2:0] start_s;
  logic start_a_s;
  logic start_b_s;
  logic start_c_s;
  logic cs_n_s;
  logic rd_n_s;
  logic fs_n_s;
  logic sclk_s;
  logic sel_a_s;
  logic [2:0] start_d;
  logic [2:0] start_rise;
  logic [2:0] pair_go;
  logic [2:0] pair_busy;
  logic [2:0] pair_done;
  logic [2:0] pair_pd;
  logic seq_on;
  logic hw_mode;
  logic rd_d;
  logic rd_fall;
  logic fs_d;
  logic fs_fall;
  logic sclk_d;
  logic sclk_fall;
  logic any_busy;
  logic any_busy_d;
  logic all_done;
  logic seq_pulse;
  logic conv_flag;
  logic int_flag;
  logic [15:0] out_reg [3];
  logic [1:0] rd_idx;
  logic [47:0] shifter;
  logic [acs_pkg::ACS_BITS_W+1:0] bit_cnt;
  logic frame_on;

  acs_sync #(.W(3)) u_sync_start (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({i_start_pair_c, i_start_pair_b, i_start_pair_a}),
    .o_sync(start_s)
  );
  acs_sync #(.W(5)) u_sync_host (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({~i_cs_n, ~i_rd_n, ~i_frame_sync_n, i_sclk, i_sel_a}),
    .o_sync({cs_n_s, rd_n_s, fs_n_s, sclk_s, sel_a_s})
  );
  assign start_a_s = start_s[acs_pkg::ACS_IDX_A];
  assign start_b_s = start_s[acs_pkg::ACS_IDX_B];
  assign start_c_s = start_s[acs_pkg::ACS_IDX_C];

  // control word, default on reset
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_control_word <= acs_pkg::ACS_CTRL_RESET;
    end else if (i_ctrl_we && !i_config_source_select) begin
      o_control_word <= o_control_word;
    end else if (i_ctrl_we) begin
      o_control_word <= i_ctrl_wdata;
    end
  end
  assign seq_on = o_control_word[acs_pkg::ACS_SEQ_BIT] && !hw_mode;
  assign hw_mode = !i_config_source_select;

  // start edge detection
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_d <= '0;
    end else begin
      start_d <= start_s;
    end
  end
  assign start_rise = start_s & ~start_d;

  // start routing per configuration source
  always_comb begin
    if (hw_mode) begin
      pair_go = start_rise;
    end else if (seq_on) begin
      pair_go = start_rise;
    end else begin
      pair_go = {3{start_rise[acs_pkg::ACS_IDX_A]}};
    end
  end

  generate
    for (genvar p = 0; p < acs_pkg::ACS_PAIRS; p++) begin : g_pair
      acs_pair u_pair (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_start(pair_go[p]),
        .i_hold_level(start_s[p]),
        .i_check_hold(hw_mode),
        .o_busy(pair_busy[p]),
        .o_done(pair_done[p]),
        .o_power_down(pair_pd[p])
      );
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_power_down <= '0;
    end else begin
      o_power_down <= pair_pd;
    end
  end

  // latch results into the output register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_reg[0] <= '0;
      out_reg[1] <= '0;
      out_reg[2] <= '0;
    end else begin
      if (pair_done[0]) out_reg[0] <= i_result_a;
      if (pair_done[1]) out_reg[1] <= i_result_b;
      if (pair_done[2]) out_reg[2] <= i_result_c;
    end
  end

  assign any_busy = |pair_busy;
  assign all_done = any_busy_d && !any_busy;
  assign seq_pulse = |pair_done;

  // conversion flag for busy, spans start to result latch
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      any_busy_d <= 1'b0;
      conv_flag <= 1'b0;
    end else begin
      any_busy_d <= any_busy;
      if (|pair_go) begin
        conv_flag <= 1'b1;
      end else if (all_done) begin
        conv_flag <= 1'b0;
      end
    end
  end

  // read strobe and frame edges
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_d <= 1'b0;
      fs_d <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      rd_d <= rd_n_s;
      fs_d <= fs_n_s;
      sclk_d <= sclk_s;
    end
  end
  assign rd_fall = rd_n_s && !rd_d && cs_n_s && !i_interface_select;
  assign fs_fall = fs_n_s && !fs_d && i_interface_select;
  assign sclk_fall = !sclk_s && sclk_d;

  // interrupt: set on completion wins over read clear
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      int_flag <= 1'b0;
    end else if (all_done) begin
      int_flag <= 1'b1;
    end else if ((rd_fall && rd_idx == 2'h2) || (fs_fall)) begin
      int_flag <= 1'b0;
    end
  end

  // busy or interrupt output
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy_int <= 1'b0;
    end else if (i_busy_as_int) begin
      o_busy_int <= int_flag || all_done;
    end else if (seq_on) begin
      o_busy_int <= conv_flag && !seq_pulse;
    end else begin
      o_busy_int <= conv_flag && !all_done;
    end
  end

  // parallel read index steps a, b, c per read
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_idx <= '0;
    end else if (all_done) begin
      rd_idx <= '0;
    end else if (rd_fall) begin
      rd_idx <= (rd_idx == 2'h2) ? 2'h0 : rd_idx + 2'h1;
    end
  end

  // parallel data pins
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_db <= '0;
      o_db_oe <= '0;
    end else if (!i_interface_select && cs_n_s && rd_n_s) begin
      // word taken at strobe fall, held while rd_idx steps on
      if (rd_fall) begin
        o_db <= out_reg[rd_idx];
      end
      o_db_oe <= 16'hFFFF;
    end else begin
      o_db <= '0;
      o_db_oe <= 16'h0000;
    end
  end

  // serial frame: a, b, c words shifted msb first on serial_out_a
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shifter <= '0;
      bit_cnt <= '0;
      frame_on <= 1'b0;
    end else if (fs_fall) begin
      shifter <= {out_reg[0], out_reg[1], out_reg[2]};
      bit_cnt <= '0;
      frame_on <= 1'b1;
    end else if (frame_on && sclk_fall) begin
      shifter <= {shifter[46:0], 1'b0};
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == 7'h2F) frame_on <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_out_a <= 1'b0;
      o_serial_out_a_oe <= 1'b0;
    end else begin
      o_serial_out_a <= shifter[47];
      o_serial_out_a_oe <= i_interface_select && sel_a_s;
    end
  end

  logic unused_db;
  assign unused_db = ^i_db;
endmodule : acs_core
`default_nettype wire

// ### bench/acs_host.sv
// host model: one parallel word read per request
// assumes bus wire level resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  input wire logic i_sys_clk,
  input wire logic i_read,
  input wire logic i_use_cs,
  input wire logic [15:0] i_db_wire,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_done,
  output logic [15:0] o_word
);
  logic [2:0] cnt = 3'h0;
  initial o_cs_n = 1'b1;
  initial o_rd_n = 1'b1;
  initial o_word = 16'h0000;
  assign o_done = (cnt == 3'h0);
  always @(posedge i_sys_clk) begin
    if (i_read) begin
      cnt <= 3'h6;
      o_cs_n <= !i_use_cs;
      o_rd_n <= 1'b0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        o_word <= i_db_wire;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
      end
    end
  end
endmodule : acs_host
`default_nettype wire

// ### bench/acs_core_properties.sv
// port checker for the conversion start and host port
// assumes one clock, async active low reset
`timescale 1ns/1ps
`default_nettype none
module acs_core_properties (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_config_source_select,
  input wire logic i_interface_select,
  input wire logic i_busy_as_int,
  input wire logic i_start_pair_a,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_sel_a,
  input wire logic [15:0] o_db_oe,
  input wire logic o_serial_out_a_oe,
  input wire logic o_busy_int,
  input wire logic [2:0] o_power_down,
  input wire logic [31:0] o_control_word
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_db_oe_whole: assert property (o_db_oe == 16'h0000 || o_db_oe == 16'hFFFF)
    else $error("bus enable split");
  a_rd_release: assert property ($past(i_rd_n) && $past(i_rd_n, 2) && $past(i_rd_n, 3) && $past(i_rd_n, 4)
    |-> o_db_oe == 16'h0000) else $error("bus driven with read strobe high");
  a_cs_release: assert property ($past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3) && $past(i_cs_n, 4)
    |-> o_db_oe == 16'h0000) else $error("bus driven with select high");
  a_serial_no_bus: assert property ($past(i_interface_select) && $past(i_interface_select, 2)
    && $past(i_interface_select, 3) |-> o_db_oe == 16'h0000) else $error("bus driven in serial mode");
  a_reset_default: assert property ($rose(i_resetn) |-> o_control_word == 32'h000003FF)
    else $error("control word not default");
  a_busy_start: assert property (!i_config_source_select && !i_busy_as_int && $rose(i_start_pair_a)
    && !o_busy_int |-> ##[1:6] o_busy_int) else $error("no busy after start");
  a_busy_length: assert property ($rose(o_busy_int) && !i_busy_as_int && !o_control_word[23]
    |-> o_busy_int [*8] ##[4:8] !o_busy_int) else $error("busy length wrong");
  a_pd_cause: assert property ($rose(o_power_down[0]) |-> !$past(i_start_pair_a)
    || !$past(i_start_pair_a, 2) || !$past(i_start_pair_a, 3)) else $error("power down without low start");
  a_serial_select: assert property (o_serial_out_a_oe |-> $past(i_sel_a) || $past(i_sel_a, 2)
    || $past(i_sel_a, 3)) else $error("serial output on while deselected");
endmodule : acs_core_properties
bind acs_core acs_core_properties i_props (.i_sys_clk, .i_resetn, .i_config_source_select,
  .i_interface_select, .i_busy_as_int, .i_start_pair_a, .i_cs_n, .i_rd_n, .i_sel_a,
  .o_db_oe, .o_serial_out_a_oe, .o_busy_int, .o_power_down, .o_control_word);
`default_nettype wire

// ### bench/test_adc_conversion_start_and_host_port.sv
// self-checking bench for the conversion start and host port
// assumes 10 MHz clock and the host model on the parallel pins
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_start_and_host_port;
  logic i_sys_clk = 0, i_resetn = 0, cfg = 0, ifs = 0, bint = 0, sa = 0, sb = 0, sc = 0;
  logic fs_n = 1, sclk = 0, sel_a = 1, we = 0, go = 0, use_cs = 1, cs_n, rd_n, hdone, so, so_oe, busy;
  logic [15:0] ra = 0, rb = 0, rc = 0, noise = 0, oe_seen = 0, wire_db, word, db, db_oe, w, v;
  logic [31:0] wd = 0, lf = 32'h0192, cw;
  logic [2:0] pd;
  int mismatches = 0, compares = 0, hi, i;
  always #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) noise <= ~noise + 16'h1357;
  always @(posedge i_sys_clk) oe_seen <= go ? 16'h0000 : (oe_seen | db_oe);
  assign wire_db = (db & db_oe) | (noise & ~db_oe);
  acs_core i_acs_core (.i_sys_clk, .i_resetn, .i_config_source_select(cfg), .i_interface_select(ifs),
    .i_busy_as_int(bint), .i_start_pair_a(sa), .i_start_pair_b(sb), .i_start_pair_c(sc), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_frame_sync_n(fs_n), .i_sclk(sclk), .i_sel_a(sel_a), .i_db(wire_db), .i_ctrl_we(we),
    .i_ctrl_wdata(wd), .i_result_a(ra), .i_result_b(rb), .i_result_c(rc), .o_db(db), .o_db_oe(db_oe),
    .o_serial_out_a(so), .o_serial_out_a_oe(so_oe), .o_busy_int(busy), .o_power_down(pd), .o_control_word(cw));
  acs_host i_acs_host (.i_sys_clk, .i_read(go), .i_use_cs(use_cs), .i_db_wire(wire_db), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_done(hdone), .o_word(word));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc
  task wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl) begin
      @(posedge i_sys_clk);
      n++;
      if (n > 200) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_busy
  task rd(input logic cs_low, input logic [15:0] exp_oe, output logic [15:0] got);
    int n;
    n = 0;
    @(posedge i_sys_clk) use_cs <= cs_low;
    go <= 1;
    @(posedge i_sys_clk) go <= 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (hdone !== 1'b1 && n < 20);
    cyc(1);
    got = word;
    chk(oe_seen, exp_oe);
    if (n >= 20) mismatches++;
    cyc(4);
  endtask : rd
  task conv(input logic [2:0] pins, input logic [15:0] va, output int n);
    @(posedge i_sys_clk) {sc, sb, sa} <= pins;
    ra <= va;
    rb <= lf[31:16];
    rc <= ~lf[15:0];
    lf = nx(lf);
    wait_busy(1, n);
    wait_busy(0, n);
    @(posedge i_sys_clk) {sc, sb, sa} <= 3'h0;
    cyc(3);
  endtask : conv
  task rd3;
    rd(1, 16'hFFFF, w); chk(w, ra);
    rd(1, 16'hFFFF, w); chk(w, rb);
    rd(1, 16'hFFFF, w); chk(w, rc);
  endtask : rd3
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1;
    cyc(2);
    chk(cw, acs_pkg::ACS_CTRL_RESET);
    chk({pd, busy, db_oe}, 0);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0001 : (i == 1) ? 16'h8000 : lf[15:0];
      conv(3'h7, v, hi); chk(hi, acs_pkg::ACS_CONV_CYC);
      rd3();
      rd(0, 16'h0000, w);
    end
    $display("parallel test done");
    bint <= 1;
    @(posedge i_sys_clk) {sc, sb, sa} <= 3'h7;
    ra <= lf[15:0];
    wait_busy(1, hi);
    @(posedge i_sys_clk) {sc, sb, sa} <= 3'h0;
    rd(1, 16'hFFFF, w); chk(w, ra);
    rd(1, 16'hFFFF, w); chk(busy, 1);
    rd(1, 16'hFFFF, w); chk(busy, 0);
    bint <= 0;
    $display("interrupt test done");
    @(posedge i_sys_clk) sa <= 1;
    cyc(12);
    sa <= 0;
    cyc(30);
    chk(pd, 3'h1);
    conv(3'h1, lf[15:0], hi); chk(pd, 3'h0);
    $display("power down test done");
    cfg <= 1;
    @(posedge i_sys_clk) we <= 1;
    wd <= lf & 32'hFF7FFFFF;
    @(posedge i_sys_clk) we <= 0;
    cyc(3);
    chk(cw, wd);
    @(posedge i_sys_clk) sb <= 1;
    cyc(25);
    chk(busy, 0);
    sb <= 0;
    conv(3'h1, lf[15:0], hi); chk(hi, acs_pkg::ACS_CONV_CYC);
    rd3();
    @(posedge i_sys_clk) we <= 1;
    wd <= wd | 32'h00800000;
    @(posedge i_sys_clk) we <= 0;
    cyc(3);
    conv(3'h2, lf[15:0], hi); chk(hi, acs_pkg::ACS_CONV_CYC);
    $display("register mode test done");
    cfg <= 0;
    ifs <= 1;
    v = lf[15:0];
    conv(3'h1, v, hi);
    @(posedge i_sys_clk) fs_n <= 0;
    for (i = 0; i < 16; i++) begin
      cyc(6);
      w = {w[14:0], so};
      sclk <= 1;
      cyc(6);
      sclk <= 0;
    end
    chk(w, v);
    chk(so_oe, 1);
    fs_n <= 1;
    rd(1, 16'h0000, w);
    @(posedge i_sys_clk) sel_a <= 0;
    cyc(6);
    chk(so_oe, 0);
    $display("serial test done");
    report_and_stop();
  end
endmodule : test_adc_conversion_start_and_host_port
`default_nettype wire
